// ==== hw/ingress_basic_classifier.sv ====
// ingress basic classifier: vlan, aggregation codes and cpu trapping
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module ingress_basic_classifier
  import basic_class_pkg::*;
(
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  // register port
  input  wire logic [basic_class_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  // parsed frame in
  input  wire logic                           frame_valid,
  input  wire basic_class_pkg::frame_t        frame,
  // classification out
  output logic                                result_valid,
  output basic_class_pkg::result_t            result
);
  import basic_class_pkg::*;

  logic [31:0] cfg [0:N_CFG-1];
  logic [15:0] lfsr;
  logic [15:0] frame_count;

  logic [31:0] vlan_ctrl, lag_hash_config, capture, queue_map, regf_cfg;
  assign vlan_ctrl       = cfg[REG_VLAN_CTRL];
  assign lag_hash_config = cfg[REG_LAG_HASH];
  assign capture         = cfg[REG_CAPTURE];
  assign queue_map       = cfg[REG_QUEUE_MAP];
  assign regf_cfg        = cfg[REG_REGFRAME];

  function automatic logic [2:0] tag_type_of(input logic [15:0] t,
                                             input logic [15:0] x0,
                                             input logic [15:0] x1,
                                             input logic [15:0] x2);
    if (t == TPID_C) return TT_C;
    if (t == TPID_S) return TT_S;
    if (t == x0) return TT_X0;
    if (t == x1) return TT_X1;
    if (t == x2) return TT_X2;
    return TT_NONE;
  endfunction

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < N_CFG; i++) cfg[i] <= 32'h0;
      cfg[REG_VLAN_CTRL] <= RST_VLAN_CTRL;
    end else if (ce && reg_wr && reg_addr < REG_STATUS) begin
      cfg[reg_addr] <= reg_wdata;
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (ce) begin
      if (!reg_rd) reg_rdata <= 32'h0;
      else if (reg_addr < REG_STATUS) reg_rdata <= cfg[reg_addr];
      else if (reg_addr == REG_STATUS) reg_rdata <= {16'h0, frame_count};
      else reg_rdata <= 32'h0;
    end
  end

  // free running so back-to-back frames still see new values
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfsr <= LFSR_SEED;
    end else if (ce) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // ---- tag parsing
  logic [2:0][2:0] raw_type;
  logic [2:0]      tag_ok;
  logic [1:0]      nvalid;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      raw_type[i] = tag_type_of(frame.tpid[i], cfg[REG_TPID0][15:0],
                                cfg[REG_TPID1][15:0],
                                cfg[REG_TPID2][15:0]);
      tag_ok[i] = (2'(i) < frame.tag_count) && raw_type[i] != TT_NONE &&
                  !vlan_ctrl[VC_TDIS + raw_type[i] - 1];
    end
    // parsing halts at the first invalid tag
    if (!tag_ok[0]) nvalid = 2'd0;
    else if (!tag_ok[1]) nvalid = 2'd1;
    else if (!tag_ok[2]) nvalid = 2'd2;
    else nvalid = 2'd3;
  end

  logic        use_inner;
  logic [15:0] sel_tci;
  logic [2:0]  sel_type;
  assign use_inner = vlan_ctrl[VC_INNER] && nvalid >= 2'd2;
  assign sel_tci   = use_inner ? frame.tci[1] : frame.tci[0];
  assign sel_type  = use_inner ? raw_type[1] : raw_type[0];

  logic        is_ip, l4_clean;
  logic [3:0]  aggr_hash, aggr_code, ecmp_code;
  logic [7:0]  cpu_mask;
  logic        redirect, copy_hit, discard_hit;

  result_t next_result;
  always_comb begin
    next_result = '0;
    if (nvalid != 2'd0) begin
      next_result.pcp      = sel_tci[15:13];
      next_result.dei      = sel_tci[12];
      // a priority tag keeps the port vid
      next_result.vid      = (sel_tci[11:0] == 12'h0) ?
                             vlan_ctrl[VC_VID +: 12] : sel_tci[11:0];
      next_result.tag_type = sel_type;
    end else begin
      next_result.pcp      = vlan_ctrl[VC_PCP +: 3];
      next_result.dei      = vlan_ctrl[VC_DEI];
      next_result.vid      = vlan_ctrl[VC_VID +: 12];
      next_result.tag_type = TT_NONE;
    end
    next_result.pop  = (vlan_ctrl[VC_POP +: 2] > nvalid) ?
                       nvalid : vlan_ctrl[VC_POP +: 2];
    next_result.push = vlan_ctrl[VC_PUSH +: 2];
    next_result.was_tagged = vlan_ctrl[VC_AWARE] && nvalid != 2'd0;
    next_result.aggr_code  = aggr_code;
    next_result.ecmp_code  = ecmp_code;
    next_result.cpu_mask   = cpu_mask;
    next_result.redirect   = redirect;
    next_result.copy       = copy_hit;
    next_result.discard    = discard_hit;
  end

  // ---- aggregation codes
  assign is_ip    = frame.is_ip4 || frame.is_ip6;
  assign l4_clean = frame.l4_valid && !frame.fragmented &&
                    !frame.ip4_options;
  always_comb begin
    aggr_hash = 4'h0;
    if (lag_hash_config[LH_DMAC])
      aggr_hash ^= fold4({80'h0, frame.dmac});
    if (lag_hash_config[LH_FLIP])
      aggr_hash ^= fold4({80'h0, flip48(frame.dmac)});
    if (lag_hash_config[LH_SMAC])
      aggr_hash ^= fold4({80'h0, frame.smac});
    if (lag_hash_config[LH_FLOW] && frame.is_ip6)
      aggr_hash ^= fold4({108'h0, frame.flow_label});
    if (lag_hash_config[LH_IP] && is_ip)
      aggr_hash ^= fold4(frame.sip) ^ fold4(frame.dip);
    if (lag_hash_config[LH_PORTS] && is_ip && frame.l4_valid)
      aggr_hash ^= fold4({96'h0, frame.sport, frame.dport});
    if (lag_hash_config[LH_RAND])
      aggr_hash ^= lfsr[3:0];
    aggr_code = (lag_hash_config[LH_STACK] && frame.stack_present) ?
                frame.stack_ac : aggr_hash;
    ecmp_code = 4'h0;
    if (is_ip) begin
      ecmp_code = fold4(frame.sip) ^
                  fold4({108'h0, frame.flow_label});
      if (l4_clean)
        ecmp_code ^= fold4({96'h0, frame.sport, frame.dport});
    end
  end

  // ---- cpu forwarding
  logic trap_ok;
  // the outer tpid filter looks at any recognised tag, not only valid ones
  assign trap_ok = frame.from_virtual_device || frame.tag_count == 2'd0 ||
                   (raw_type[0] != TT_NONE &&
                    !capture[CP_TDIS + raw_type[0] - 1]);

  logic [1:0] act_bpdu, act_garp, act_cfm;
  logic       mac4mc, mac6mc;
  logic       igmp_hit, mld_hit, hbh_hit, ip4mc_hit, ip6mc_hit;
  assign act_bpdu = (frame.dmac[47:4] == MAC_BPDU) ?
                    capture[CP_BPDU +: 2] : ACT_NONE;
  assign act_garp = (frame.dmac[47:4] == MAC_GARP) ?
                    capture[CP_GARP +: 2] : ACT_NONE;
  assign act_cfm  = (frame.dmac[47:4] == MAC_CFM) ?
                    capture[CP_CFM +: 2] : ACT_NONE;
  assign mac4mc = frame.dmac[47:23] == MAC_IP4MC;
  assign mac6mc = frame.dmac[47:32] == MAC_IP6MC;
  assign igmp_hit = capture[CP_IGMP] && mac4mc && frame.is_ip4 &&
                    frame.ip_proto == PROTO_IGMP;
  assign mld_hit  = capture[CP_MLD] && mac6mc && frame.is_ip6 &&
                    frame.ip_proto == PROTO_HBH &&
                    frame.opt_type == RA_TYPE && frame.opt_len == RA_LEN &&
                    frame.opt_data == RA_DATA;
  assign hbh_hit  = frame.is_ip6 &&
                    ((capture[CP_HBH] && frame.ip_proto == PROTO_HBH) ||
                     (capture[CP_ICMP] &&
                      frame.ip_proto == PROTO_ICMP6));
  assign ip4mc_hit = capture[CP_IP4MC] && mac4mc && frame.is_ip4 &&
                     frame.ip_proto != PROTO_IGMP &&
                     frame.dip[31:8] == DIP4_CTRL;
  assign ip6mc_hit = capture[CP_IP6MC] && mac6mc && frame.is_ip6 &&
                     frame.ip_proto != PROTO_HBH &&
                     frame.ip_proto != PROTO_ICMP6 &&
                     frame.dip[127:112] == DIP6_CTRL;

  // register access frame
  logic regf_vlan_ok, regf_hit;
  always_comb begin
    if (regf_cfg[RF_AWARE])
      regf_vlan_ok = frame.tag_count == 2'd1 &&
                     frame.tci[0][11:0] == regf_cfg[RF_VID +: 12];
    else
      regf_vlan_ok = frame.tag_count == 2'd0;
    regf_hit = capture[CP_REGF] && regf_vlan_ok &&
               frame.etype == ETYPE_REGF &&
               frame.protocol_id_field == PROTOCOL_ID_FIELD_REGF &&
               ((frame.regframe_hdr ^ cfg[REG_HDR_MATCH]) &
                ~cfg[REG_HDR_DC]) == 32'h0;
  end

  always_comb begin
    cpu_mask    = 8'h0;
    redirect    = 1'b0;
    copy_hit    = 1'b0;
    discard_hit = 1'b0;
    if (trap_ok) begin
      if (act_bpdu == ACT_COPY || act_bpdu == ACT_REDIR)
        cpu_mask |= qbit(queue_map[Q_BPDU +: 3]);
      if (act_garp == ACT_COPY || act_garp == ACT_REDIR)
        cpu_mask |= qbit(queue_map[Q_GARP +: 3]);
      if (act_cfm == ACT_COPY || act_cfm == ACT_REDIR)
        cpu_mask |= qbit(queue_map[Q_CFM +: 3]);
      if (igmp_hit) cpu_mask |= qbit(queue_map[Q_IGMP +: 3]);
      if (mld_hit) cpu_mask |= qbit(queue_map[Q_MLD +: 3]);
      if (hbh_hit) cpu_mask |= qbit(queue_map[Q_HBH +: 3]);
      if (ip4mc_hit) cpu_mask |= qbit(queue_map[Q_IP4MC +: 3]);
      if (ip6mc_hit) cpu_mask |= qbit(queue_map[Q_IP6MC +: 3]);
      redirect = act_bpdu == ACT_REDIR || act_garp == ACT_REDIR ||
                 act_cfm == ACT_REDIR || igmp_hit || mld_hit ||
                 hbh_hit;
      copy_hit = act_bpdu == ACT_COPY || act_garp == ACT_COPY ||
                 act_cfm == ACT_COPY || ip4mc_hit || ip6mc_hit;
      discard_hit = act_bpdu == ACT_DISCARD || act_garp == ACT_DISCARD ||
                    act_cfm == ACT_DISCARD;
    end
    if (regf_hit) begin
      cpu_mask |= qbit(queue_map[Q_REGF +: 3]);
      redirect = 1'b1;
    end
  end

  // ---- result stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_valid <= 1'b0;
      result       <= '0;
    end else if (ce) begin
      result_valid <= frame_valid;
      if (frame_valid) result <= next_result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) frame_count <= 16'h0;
    else if (ce && frame_valid) frame_count <= frame_count + 16'h1;
  end

  // ---- checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_pop_clamp;
    ce && frame_valid |=> result.pop <= $past(nvalid) &&
      result.pop <= $past(vlan_ctrl[VC_POP +: 2]);
  endproperty
  a_pop_clamp: assert property (p_pop_clamp)
    else $error("pop count not clamped");

  property p_was_tagged;
    ce && frame_valid |=> result.was_tagged ==
      ($past(vlan_ctrl[VC_AWARE]) && $past(nvalid) != 2'd0);
  endproperty
  a_was_tagged: assert property (p_was_tagged)
    else $error("was-tagged flag wrong");

  property p_default_vid;
    ce && frame_valid && nvalid == 2'd0 |=>
      result.vid == $past(vlan_ctrl[VC_VID +: 12]) &&
      result.tag_type == TT_NONE;
  endproperty
  a_default_vid: assert property (p_default_vid)
    else $error("untagged frame lost port defaults");

  property p_inner_tag;
    ce && frame_valid && use_inner && frame.tci[1][11:0] != 12'h0 |=>
      result.vid == $past(frame.tci[1][11:0]);
  endproperty
  a_inner_tag: assert property (p_inner_tag)
    else $error("inner tag not used");

  property p_stack_override;
    ce && frame_valid && lag_hash_config[LH_STACK] && frame.stack_present
      |=> result.aggr_code == $past(frame.stack_ac);
  endproperty
  a_stack_override: assert property (p_stack_override)
    else $error("stack header code ignored");

  property p_redirect_mask;
    result_valid && result.redirect |-> result.cpu_mask != 8'h0;
  endproperty
  a_redirect_mask: assert property (p_redirect_mask)
    else $error("redirect without cpu queue");

  property p_regframe;
    ce && frame_valid && regf_hit |=> result.redirect &&
      (result.cpu_mask & qbit($past(queue_map[Q_REGF +: 3]))) != 8'h0;
  endproperty
  a_regframe: assert property (p_regframe)
    else $error("register frame not redirected");

  property p_trap_filter;
    ce && frame_valid && !trap_ok && !regf_hit |=>
      result.cpu_mask == 8'h0 && !result.redirect && !result.copy;
  endproperty
  a_trap_filter: assert property (p_trap_filter)
    else $error("filtered frame forwarded to cpu");

  property p_igmp;
    ce && frame_valid && trap_ok && igmp_hit |=> result.redirect;
  endproperty
  a_igmp: assert property (p_igmp)
    else $error("igmp frame not redirected");

  property p_ecmp_non_ip;
    ce && frame_valid && !is_ip |=> result.ecmp_code == 4'h0;
  endproperty
  a_ecmp_non_ip: assert property (p_ecmp_non_ip)
    else $error("ecmp code set for non-ip frame");

  property p_tag_halt;
    ce && frame_valid && !tag_ok[0] |=> !result.was_tagged &&
      result.pop == 2'd0;
  endproperty
  a_tag_halt: assert property (p_tag_halt)
    else $error("tags used after an invalid outer tpid");

  // a stuck lfsr would pin every random hash term to one link
  property p_lfsr_moves;
    !rst && ce |=> lfsr != $past(lfsr);
  endproperty
  a_lfsr_moves: assert property (p_lfsr_moves)
    else $error("random hash source stuck");

  c_redirect: cover property (result_valid && result.redirect);
  c_copy: cover property (result_valid && result.copy && !result.redirect);
  c_discard: cover property (result_valid && result.discard);
  c_inner: cover property (ce && frame_valid && use_inner);
endmodule

// ==== shared/basic_class_pkg.sv ====
// constants, types and helpers for the ingress basic classifier
package basic_class_pkg;
  localparam int ADDR_W = 4;
  localparam int N_CFG  = 10;
  // register indices
  localparam logic [3:0] REG_VLAN_CTRL   = 4'h0;
  localparam logic [3:0] REG_TPID0       = 4'h1;
  localparam logic [3:0] REG_TPID1       = 4'h2;
  localparam logic [3:0] REG_TPID2       = 4'h3;
  localparam logic [3:0] REG_LAG_HASH    = 4'h4;
  localparam logic [3:0] REG_CAPTURE     = 4'h5;
  localparam logic [3:0] REG_QUEUE_MAP   = 4'h6;
  localparam logic [3:0] REG_REGFRAME    = 4'h7;
  localparam logic [3:0] REG_HDR_MATCH   = 4'h8;
  localparam logic [3:0] REG_HDR_DC      = 4'h9;
  localparam logic [3:0] REG_STATUS      = 4'ha;
  localparam logic [31:0] RST_VLAN_CTRL  = 32'h0000_0001;
  // vlan control fields
  localparam int VC_VID = 0, VC_PCP = 12, VC_DEI = 15, VC_AWARE = 16;
  localparam int VC_INNER = 17, VC_POP = 18, VC_PUSH = 20, VC_TDIS = 22;
  // lag hash enables
  localparam int LH_DMAC = 0, LH_FLIP = 1, LH_SMAC = 2, LH_FLOW = 3;
  localparam int LH_IP = 4, LH_PORTS = 5, LH_RAND = 6, LH_STACK = 7;
  // capture and register frame fields
  localparam int CP_BPDU = 0, CP_GARP = 2, CP_CFM = 4, CP_IGMP = 6;
  localparam int CP_MLD = 7, CP_HBH = 8, CP_ICMP = 9, CP_IP4MC = 10;
  localparam int CP_IP6MC = 11, CP_TDIS = 12, CP_REGF = 17;
  localparam int RF_VID = 0, RF_AWARE = 12;
  // queue map slots, three bits each
  localparam int Q_BPDU = 0, Q_GARP = 3, Q_CFM = 6, Q_IGMP = 9, Q_MLD = 12;
  localparam int Q_HBH = 15, Q_IP4MC = 18, Q_IP6MC = 21, Q_REGF = 24;
  // l2 control actions
  localparam logic [1:0] ACT_NONE = 2'h0, ACT_COPY = 2'h1;
  localparam logic [1:0] ACT_REDIR = 2'h2, ACT_DISCARD = 2'h3;
  // tag types
  localparam logic [2:0] TT_NONE = 3'h0, TT_C = 3'h1, TT_S = 3'h2;
  localparam logic [2:0] TT_X0 = 3'h3, TT_X1 = 3'h4, TT_X2 = 3'h5;
  localparam logic [15:0] TPID_C = 16'h8100, TPID_S = 16'h88a8;
  localparam logic [15:0] ETYPE_REGF = 16'h8880, PROTOCOL_ID_FIELD_REGF = 16'h0004;
  localparam logic [7:0]  PROTO_HBH = 8'h00, PROTO_IGMP = 8'h02;
  localparam logic [7:0]  PROTO_ICMP6 = 8'h3a;
  localparam logic [7:0]  RA_TYPE = 8'h05, RA_LEN = 8'h02;
  localparam logic [15:0] RA_DATA = 16'h0000;
  localparam logic [43:0] MAC_BPDU = 44'h0180c200000;
  localparam logic [43:0] MAC_GARP = 44'h0180c200002;
  localparam logic [43:0] MAC_CFM  = 44'h0180c200003;
  localparam logic [24:0] MAC_IP4MC = 25'h0200bc; // 01005e, bit 23 clear
  localparam logic [15:0] MAC_IP6MC = 16'h3333;
  localparam logic [23:0] DIP4_CTRL = 24'he00000;
  localparam logic [15:0] DIP6_CTRL = 16'hff02;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef struct packed {
    logic [2:0][15:0] tpid;     // index 0 is the outer tag
    logic [2:0][15:0] tci;
    logic [1:0]       tag_count;
    logic [47:0]      dmac;
    logic [47:0]      smac;
    logic [15:0]      etype;
    logic             is_ip4;
    logic             is_ip6;
    logic [7:0]       ip_proto;
    logic [127:0]     sip;
    logic [127:0]     dip;
    logic [19:0]      flow_label;
    logic             l4_valid;
    logic [15:0]      sport;
    logic [15:0]      dport;
    logic             fragmented;
    logic             ip4_options;
    logic [7:0]       opt_type;
    logic [7:0]       opt_len;
    logic [15:0]      opt_data;
    logic             stack_present;
    logic [3:0]       stack_ac;
    logic [15:0]      protocol_id_field;
    logic [31:0]      regframe_hdr;
    logic             from_virtual_device;
  } frame_t;

  typedef struct packed {
    logic [2:0]  pcp;
    logic        dei;
    logic [11:0] vid;
    logic [2:0]  tag_type;
    logic [1:0]  pop;
    logic [1:0]  push;
    logic        was_tagged;
    logic [3:0]  aggr_code;
    logic [3:0]  ecmp_code;
    logic [7:0]  cpu_mask;
    logic        redirect;
    logic        copy;
    logic        discard;
  } result_t;

  function automatic logic [3:0] fold4(input logic [127:0] v);
    logic [3:0] a;
    a = 4'h0;
    for (int i = 0; i < 32; i++) a ^= v[4*i +: 4];
    return a;
  endfunction

  function automatic logic [47:0] flip48(input logic [47:0] v);
    logic [47:0] r;
    r = 48'h0;
    for (int i = 0; i < 48; i++) r[i] = v[47-i];
    return r;
  endfunction

  function automatic logic [7:0] qbit(input logic [2:0] q);
    return 8'h01 << q;
  endfunction
endpackage

// ==== tb/result_sink.sv ====
// downstream model: latches each classification and counts frames
`timescale 1ns/1ps
module result_sink
  import basic_class_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // classification in
  input  wire logic                     result_valid,
  input  wire basic_class_pkg::result_t result,
  // observed
  output basic_class_pkg::result_t      got,
  output logic [15:0]                   n_seen
);
  import basic_class_pkg::*;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      got    <= '0;
      n_seen <= 16'h0000;
    end else if (result_valid) begin
      got    <= result;
      n_seen <= n_seen + 16'h0001;
    end
  end
endmodule

// ==== tb/tb_ingress_basic_classifier.sv ====
// self-checking bench for the ingress basic classifier
`timescale 1ns/1ps
module tb_ingress_basic_classifier;
  import basic_class_pkg::*;
  typedef struct packed {
    logic [31:0]      vc;
    logic [2:0][15:0] tp;
    logic [2:0][15:0] tc;
    logic [1:0]       cnt;
    logic [23:0]      ex;
  } row_t;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic [31:0]       reg_rdata;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              frame_valid = 1'b0;
  logic              result_valid;
  frame_t            frame = '0;
  frame_t            f;
  result_t           result;
  result_t           got;
  logic [15:0]       n_seen;
  logic [3:0]        ex;
  logic [7:0]        lc [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h87};
  row_t              rows [9];
  int                miscompares = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                nf = 0;
  localparam logic [15:0] X = 16'h9100;

  ingress_basic_classifier DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
    .frame(frame), .result_valid(result_valid), .result(result));
  result_sink sink (.sys_clk(sys_clk), .rst(rst),
    .result_valid(result_valid), .result(result), .got(got),
    .n_seen(n_seen));

  always #12.5 sys_clk = ~sys_clk;
  // hang guard, far above the roughly 160 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic send(frame_t fr);
    @(posedge sys_clk);
    frame <= fr;
    frame_valid <= 1'b1;
    @(posedge sys_clk);
    frame_valid <= 1'b0;
    nf++;
    #1 chk("result_valid", 32'h1, 32'(result_valid));
  endtask
  task automatic trap(logic [7:0] m, logic [2:0] fl);
    send(f);
    chk("cpu_mask", 32'(m), 32'(result.cpu_mask));
    chk("redir copy drop", 32'(fl),
        32'({result.redirect, result.copy, result.discard}));
  endtask
  // own nibble fold, kept apart from the design's helper
  function automatic logic [3:0] xf(logic [127:0] v);
    xf = 4'h0;
    for (int i = 0; i < 128; i += 4) xf = xf ^ v[i +: 4];
  endfunction
  function automatic logic [47:0] rv(logic [47:0] v);
    for (int i = 0; i < 48; i++) rv[i] = v[47-i];
  endfunction
  function automatic logic [23:0] e(logic [2:0] p, logic d, logic [11:0] v,
    logic [2:0] t, logic [1:0] po, logic [1:0] pu, logic w);
    return {p, d, v, t, po, pu, w};
  endfunction

  initial begin
    rows[0] = '{32'h003d200a, '0, '0, 2'h0,
                e(3'h2, 1'b0, 12'h00a, TT_NONE, 2'h0, 2'h3, 1'b0)};
    rows[1] = '{32'h0001200a, {32'h0, TPID_C}, {32'h0, 16'h6005}, 2'h1,
                e(3'h3, 1'b0, 12'h005, TT_C, 2'h0, 2'h0, 1'b1)};
    rows[2] = '{32'h0001200a, {32'h0, TPID_S}, {32'h0, 16'hb000}, 2'h1,
                e(3'h5, 1'b1, 12'h00a, TT_S, 2'h0, 2'h0, 1'b1)};
    rows[3] = '{32'h000b200a, {16'h0, TPID_S, TPID_C},
                {16'h0, 16'h8009, 16'h2007}, 2'h2,
                e(3'h4, 1'b0, 12'h009, TT_S, 2'h2, 2'h0, 1'b1)};
    rows[4] = '{32'h000f200a, {X, TPID_C, TPID_C},
                {16'h6003, 16'h4002, 16'h2001}, 2'h3,
                e(3'h2, 1'b0, 12'h002, TT_C, 2'h3, 2'h0, 1'b1)};
    rows[5] = '{32'h0041200a, {32'h0, TPID_C}, {32'h0, 16'h6005}, 2'h1,
                e(3'h2, 1'b0, 12'h00a, TT_NONE, 2'h0, 2'h0, 1'b0)};
    rows[6] = '{32'h0083200a, {16'h0, TPID_C, TPID_S},
                {16'h0, 16'h2007, 16'h6005}, 2'h2,
                e(3'h2, 1'b0, 12'h00a, TT_NONE, 2'h0, 2'h0, 1'b0)};
    rows[7] = '{32'h0001200a, {32'h0, X}, {32'h0, 16'he00c}, 2'h1,
                e(3'h7, 1'b0, 12'h00c, TT_X0, 2'h0, 2'h0, 1'b1)};
    rows[8] = '{32'h000d200a, {32'h0, TPID_C}, {32'h0, 16'h0004}, 2'h1,
                e(3'h0, 1'b0, 12'h004, TT_C, 2'h1, 2'h0, 1'b1)};
    repeat (12) @(posedge sys_clk);
    chk("result_valid in reset", 32'h0, 32'(result_valid));
    rst <= 1'b0;
    rd(REG_VLAN_CTRL, RST_VLAN_CTRL);
    rd(4'hb, 32'h0);
    wr(REG_TPID0, {16'h0, X});
    foreach (rows[i]) begin
      wr(REG_VLAN_CTRL, rows[i].vc);
      f = '0;
      f.tpid = rows[i].tp;
      f.tci = rows[i].tc;
      f.tag_count = rows[i].cnt;
      send(f);
      chk("vlan fields", 32'(rows[i].ex), 32'({result.pcp, result.dei,
          result.vid, result.tag_type, result.pop, result.push,
          result.was_tagged}));
    end
    wr(REG_VLAN_CTRL, 32'h0000200a);
    send(f);
    chk("was_tagged unaware", 32'h0, 32'(result.was_tagged));
    $display("test vlan done");
    f = '0;
    f.dmac = 48'h0000000a0001;
    f.smac = 48'h000000000a50;
    f.stack_present = 1'b1;
    f.stack_ac = 4'h6;
    foreach (lc[i]) begin
      wr(REG_LAG_HASH, 32'(lc[i]));
      ex = (lc[i][0] ? xf(128'(f.dmac)) : 4'h0)
         ^ (lc[i][1] ? xf(128'(rv(f.dmac))) : 4'h0)
         ^ (lc[i][2] ? xf(128'(f.smac)) : 4'h0);
      if (lc[i][7]) ex = f.stack_ac;
      send(f);
      chk("aggr_code", 32'(ex), 32'(result.aggr_code));
    end
    wr(REG_LAG_HASH, 32'h00000038);
    f = '0;
    f.is_ip4 = 1'b1;
    f.sip = 128'h0a000031;
    f.dip = 128'h0a0000c7;
    f.l4_valid = 1'b1;
    f.sport = 16'h1234;
    f.dport = 16'h0057;
    for (int fr = 0; fr < 2; fr++) begin
      f.fragmented = fr[0];
      send(f);
      ex = xf(f.sip) ^ (fr[0] ? 4'h0 : xf(128'({f.sport, f.dport})));
      chk("ecmp_code", 32'(ex), 32'(result.ecmp_code));
    end
    chk("aggr ip ports", 32'(xf(f.sip) ^ xf(f.dip) ^
        xf(128'({f.sport, f.dport}))), 32'(result.aggr_code));
    f.is_ip4 = 1'b0;
    f.is_ip6 = 1'b1;
    f.flow_label = 20'h5a3c1;
    f.l4_valid = 1'b0;
    send(f);
    chk("ecmp_code v6", 32'(xf(f.sip) ^ xf(128'(f.flow_label))),
        32'(result.ecmp_code));
    chk("aggr v6", 32'(xf(f.sip) ^ xf(f.dip) ^ xf(128'(f.flow_label))),
        32'(result.aggr_code));
    $display("test hash done");
    wr(REG_LAG_HASH, 32'h0);
    wr(REG_QUEUE_MAP, 32'h05118401);
    f = '0;
    f.dmac = 48'h0180c2000003;
    for (int a = 1; a < 4; a++) begin
      wr(REG_CAPTURE, 32'h000207c0 | 32'(a));
      trap(a == 3 ? 8'h00 : 8'h02, {a == 2, a == 1, a == 3});
    end
    wr(REG_CAPTURE, 32'h000217c2);
    f.tag_count = 2'h1;
    f.tpid[0] = TPID_C;
    trap(8'h00, 3'h0);
    f.from_virtual_device = 1'b1;
    trap(8'h02, 3'h4);
    f.dmac = 48'h0180c2000021;
    wr(REG_CAPTURE, 32'h00000004);
    trap(8'h01, 3'h2);
    f.dmac = 48'h0180c2000035;
    wr(REG_CAPTURE, 32'h00000020);
    trap(8'h01, 3'h4);
    wr(REG_CAPTURE, 32'h000207c0);
    f = '0;
    f.dmac = 48'h01005e000001;
    f.is_ip4 = 1'b1;
    f.dip = 128'he0000001;
    f.ip_proto = PROTO_IGMP;
    trap(8'h04, 3'h4);
    f.ip_proto = 8'h11;
    trap(8'h10, 3'h2);
    f = '0;
    f.is_ip6 = 1'b1;
    trap(8'h08, 3'h4);
    f.ip_proto = PROTO_ICMP6;
    trap(8'h08, 3'h4);
    f.ip_proto = PROTO_HBH;
    f.dmac = 48'h333300000001;
    f.opt_type = RA_TYPE;
    f.opt_len = RA_LEN;
    trap(8'h09, 3'h4);
    wr(REG_CAPTURE, 32'h00000800);
    f.ip_proto = 8'h11;
    f.dip = {16'hff02, 112'h1};
    trap(8'h01, 3'h2);
    wr(REG_CAPTURE, 32'h000207c0);
    $display("test trap done");
    wr(REG_HDR_MATCH, 32'h12345600);
    wr(REG_HDR_DC, 32'h000000ff);
    f = '0;
    f.etype = ETYPE_REGF;
    f.protocol_id_field = PROTOCOL_ID_FIELD_REGF;
    f.regframe_hdr = 32'h123456a5;
    trap(8'h20, 3'h4);
    f.regframe_hdr = 32'h133456a5;
    trap(8'h00, 3'h0);
    f.regframe_hdr = 32'h123456a5;
    wr(REG_REGFRAME, 32'h0000100c);
    trap(8'h00, 3'h0);
    f.tag_count = 2'h1;
    f.tpid[0] = TPID_C;
    f.tci[0] = 16'h000c;
    trap(8'h20, 3'h4);
    f.tag_count = 2'h2;
    f.tpid[1] = TPID_C;
    trap(8'h00, 3'h0);
    $display("test regframe done");
    @(posedge sys_clk);
    ce <= 1'b0;
    frame_valid <= 1'b1;
    @(posedge sys_clk);
    ce <= 1'b1;
    frame_valid <= 1'b0;
    #1 chk("result_valid ce low", 32'h0, 32'(result_valid));
    wr(4'ha, 32'h0);
    rd(REG_STATUS, 32'(nf));
    chk("sink frames", 32'(nf), 32'(n_seen));
    chk("sink last mask", 32'h0, 32'(got.cpu_mask));
    $display("test status done");
    end_sim();
  end
endmodule
